//--- rtl/pda_pwm_shutdown.sv
// output steering, dead band, auto-shutdown and register slave
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module pda_pwm_shutdown
	import pda_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	// axi4-lite write address
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [7:0] s_axi_awaddr_in,
	// axi4-lite write data
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	// axi4-lite write response
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// axi4-lite read address
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [7:0] s_axi_araddr_in,
	// axi4-lite read data
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// shutdown sources, asynchronous
	input wire logic comparator1_in,
	input wire logic comparator2_in,
	input wire logic fault_input_pin_n_in,
	// from the period and duty generator, same clock
	input wire logic period_start_in,
	input wire logic pwm_raw_in,
	// port direction per pin d,c,b,a; 1 = input
	input wire logic [3:0] pin_dir_input_in,
	// pins
	output logic pwm_out_a_out,
	output logic pwm_out_b_out,
	output logic pwm_out_c_out,
	output logic pwm_out_d_out,
	output logic pwm_oe_a_out,
	output logic pwm_oe_b_out,
	output logic pwm_oe_c_out,
	output logic pwm_oe_d_out,
	output logic shutdown_active_out
);
	// every flop of the block outside the sync and dead-band instances lives in this struct; the comb process
	// builds next_state and one clocked process copies it across
	typedef struct packed {
		logic [7:0] deadband_restart_ctrl; // auto restart + dead-band count
		logic [7:0] shutdown_ctrl; // flag, sources, pair levels
		logic [7:0] pwm_mode_ctrl; // config, duty lsbs, polarity mode
		logic hold; // shutdown held to a period boundary
		logic awready;
		logic wready;
		logic aw_got; // address taken, waiting for data
		logic w_got; // data taken, waiting for address
		logic [7:0] awaddr;
		logic [7:0] wdata; // only the low byte is stored
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [3:0] pin_val; // d,c,b,a
		logic [3:0] pin_oe;
	} pda_state_type;

	pda_state_type state;
	pda_state_type next_state;

	// glue between the helper modules and the main process
	logic [2:0] src_sync; // fault_n, comparator2, comparator1
	logic db_a; // delayed pwm for pin a
	logic db_b; // delayed complement for pin b

	// shutdown sources pass two flops before use; the extra latency is
	// two cycles before the pins react, a price paid for clean levels
	// the fault pin keeps its raw sense here and is inverted after sync
	// comparators are levels, so a short glitch below one cycle may be lost
	pda_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.async_in({fault_input_pin_n_in, comparator2_in, comparator1_in}),
		.sync_out(src_sync)
	);

	// dead band for the true half-bridge output
	// only the half-bridge steering reads this delayed level
	pda_dead_band u_db_a (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.level_in(pwm_raw_in),
		.count_in(state.deadband_restart_ctrl[DEADBAND_COUNT_W-1:0]),
		.level_out(db_a)
	);

	// dead band for the complementary output
	// the complement is delayed on its own rise, so both edges get a gap
	pda_dead_band u_db_b (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.level_in(!pwm_raw_in),
		.count_in(state.deadband_restart_ctrl[DEADBAND_COUNT_W-1:0]),
		.level_out(db_b)
	);

	// address decode shared by reads and writes
	// low two address bits are ignored: every register is one aligned word
	function automatic logic [1:0] reg_index(input logic [7:0] addr);
		case ({addr[7:2], 2'h0})
			DEADBAND_RESTART_CTRL_ADDR: reg_index = 2'h0;
			SHUTDOWN_CTRL_ADDR: reg_index = 2'h1;
			PWM_MODE_CTRL_ADDR: reg_index = 2'h2;
			default: reg_index = 2'h3; // unmapped
		endcase
	endfunction : reg_index

	// one pair's pin level: drive-low, drive-high or active level
	// polarity is applied after steering so the shutdown level is absolute
	// level and polarity are per pair, shut is common to all pins; pins a and c share one set
	function automatic logic pair_level(input logic shut, input logic [1:0] level,
			input logic active, input logic low_pol);
		if (shut) begin
			pair_level = level[0];
		end else begin
			pair_level = active ^ low_pol;
		end
	endfunction : pair_level

	// intermediate values of the main process, set at its top save flag and shut
	logic [2:0] src_active; // per source: active condition
	logic cause; // any selected source active
	logic flag; // next shutdown flag
	logic sw_flag_wr; // software writes the shutdown register
	logic shut; // outputs forced this cycle
	logic enabled; // enhanced pwm function on
	logic [1:0] cfg;
	logic [3:0] act; // active request per pin d,c,b,a
	logic [1:0] ac_level;
	logic [1:0] bd_level;

	// all next-state logic of the block
	// order matters: bus first, then the flag, then hold and pins
	always_comb begin
		next_state = state;
		// the fault pin is active low; turn every source into active high
		src_active = {!src_sync[2], src_sync[1], src_sync[0]};
		// comparators stay in as levels, so they keep the flag up
		cause = |(state.shutdown_ctrl[SOURCE_LSB +: 3] & src_active);
		sw_flag_wr = 1'b0;
		act = 4'h0;
		ac_level = state.shutdown_ctrl[AC_LEVEL_LSB +: 2];
		bd_level = state.shutdown_ctrl[BD_LEVEL_LSB +: 2];
		// configuration and enable are decoded straight from the register
		cfg = state.pwm_mode_ctrl[CONFIG_LSB +: 2];
		enabled = state.pwm_mode_ctrl[ENABLE_LSB +: 2] == PWM_ENABLE_CODE;

		// write address and data are taken in either order
		// each half is latched on its own handshake and waits for the other
		if (s_axi_awvalid_in && state.awready) begin
			next_state.aw_got = 1'b1;
			next_state.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && state.wready) begin
			next_state.w_got = 1'b1;
			next_state.wdata = s_axi_wdata_in[7:0];
			next_state.wstrb0 = s_axi_wstrb_in[0];
		end
		// response accepted: channels may reopen on the next edge
		if (state.bvalid && s_axi_bready_in) begin
			next_state.bvalid = 1'b0;
		end

		// perform a write once both halves are held
		// the write lands one edge after both halves are in, so the
		// response and the new register value show at the same edge
		if (state.aw_got && state.w_got && !state.bvalid) begin
			next_state.aw_got = 1'b0;
			next_state.w_got = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = RESP_OKAY;
			// byte lane 0 carries the register; other lanes are dropped
			case (reg_index(state.awaddr))
				2'h0: begin
					if (state.wstrb0) begin
						next_state.deadband_restart_ctrl = state.wdata;
					end
				end
				2'h1: begin
					if (state.wstrb0) begin
						// flag bit handled with the shutdown logic below
						next_state.shutdown_ctrl[FLAG_BIT-1:0] = state.wdata[FLAG_BIT-1:0];
						sw_flag_wr = 1'b1;
					end
				end
				2'h2: begin
					if (state.wstrb0) begin
						next_state.pwm_mode_ctrl = state.wdata;
					end
				end
				default: begin
					next_state.bresp = RESP_SLVERR;
				end
			endcase
		end

		// read: one cycle from address to data
		// data are captured at the taking edge and stand until rready
		if (state.rvalid && s_axi_rready_in) begin
			next_state.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && state.arready) begin
			next_state.rvalid = 1'b1;
			next_state.rresp = RESP_OKAY;
			// unused upper bits read as zero
			case (reg_index(s_axi_araddr_in))
				2'h0: begin
					next_state.rdata = {24'h000000, state.deadband_restart_ctrl};
				end
				2'h1: begin
					next_state.rdata = {24'h000000, state.shutdown_ctrl};
				end
				2'h2: begin
					next_state.rdata = {24'h000000, state.pwm_mode_ctrl};
				end
				default: begin
					next_state.rdata = 32'h00000000;
					next_state.rresp = RESP_SLVERR;
				end
			endcase
		end

		// shutdown flag: auto clear, then software, then events win
		// a cause in the same cycle as a clear always keeps the flag up;
		// a software one with auto restart on lasts one cycle, but the
		// hold below still keeps the pins shut to the next period
		flag = state.shutdown_ctrl[FLAG_BIT];
		if (state.deadband_restart_ctrl[AUTO_RESTART_BIT] && !cause) begin
			flag = 1'b0;
		end
		// without auto restart only software clears the flag
		if (sw_flag_wr && !cause) begin
			flag = state.wdata[FLAG_BIT];
		end
		if (cause) begin
			flag = 1'b1;
		end
		next_state.shutdown_ctrl[FLAG_BIT] = flag;

		// hold until a period starts with the flag clear
		// a period boundary seen while the flag is set starts a whole
		// period in shutdown, since the hold is simply renewed
		next_state.hold = flag || (state.hold && !period_start_in);
		shut = next_state.hold;

		// output steering per configuration
		// act is the active request per pin before polarity; an unused
		// pin asks for its inactive level
		// full bridge: one pin held active, the diagonal one modulated
		case (cfg)
			CONFIG_SINGLE: begin
				act = {3'h0, pwm_raw_in};
			end
			CONFIG_HALF: begin
				act = {2'h0, db_b, db_a};
			end
			CONFIG_FULL_FWD: begin
				act = {pwm_raw_in, 2'h0, 1'b1};
			end
			CONFIG_FULL_REV: begin
				act = {1'b0, 1'b1, pwm_raw_in, 1'b0};
			end
			default: begin
				act = 4'h0;
			end
		endcase

		// pin levels; a disabled unit drives plain zero
		// shutdown levels only apply while the enhanced function is on
		if (enabled) begin
			next_state.pin_val[0] = pair_level(shut, ac_level, act[0], state.pwm_mode_ctrl[AC_POL_BIT]);
			next_state.pin_val[2] = pair_level(shut, ac_level, act[2], state.pwm_mode_ctrl[AC_POL_BIT]);
			next_state.pin_val[1] = pair_level(shut, bd_level, act[1], state.pwm_mode_ctrl[BD_POL_BIT]);
			next_state.pin_val[3] = pair_level(shut, bd_level, act[3], state.pwm_mode_ctrl[BD_POL_BIT]);
		end else begin
			next_state.pin_val = 4'h0;
		end

		// release overrides direction while shut down
		// an input pin stays undriven; a released pair also drops its
		// enables so the board pull resistors set the gate level
		next_state.pin_oe[0] = !pin_dir_input_in[0] && !(enabled && shut && ac_level[1]);
		next_state.pin_oe[2] = !pin_dir_input_in[2] && !(enabled && shut && ac_level[1]);
		next_state.pin_oe[1] = !pin_dir_input_in[1] && !(enabled && shut && bd_level[1]);
		next_state.pin_oe[3] = !pin_dir_input_in[3] && !(enabled && shut && bd_level[1]);

		// ready flags from the next state so they leave flops
		// computing them from next_state keeps a channel from being taken
		// twice before its response has been accepted
		next_state.awready = !next_state.aw_got && !next_state.bvalid;
		next_state.wready = !next_state.w_got && !next_state.bvalid;
		next_state.arready = !next_state.rvalid;
	end

	// one register stage for all state; reset restores defaults
	// the reset values come from the package so the bus reads them back
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state <= '0;
			state.deadband_restart_ctrl <= DEADBAND_RESTART_CTRL_RESET;
			state.shutdown_ctrl <= SHUTDOWN_CTRL_RESET;
			state.pwm_mode_ctrl <= PWM_MODE_CTRL_RESET;
			state.pin_oe <= 4'h0;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state register
	// no logic sits between a flop and a pin, so pins cannot glitch
	assign s_axi_awready_out = state.awready;
	assign s_axi_wready_out = state.wready;
	assign s_axi_bvalid_out = state.bvalid;
	assign s_axi_bresp_out = state.bresp;
	assign s_axi_arready_out = state.arready;
	assign s_axi_rvalid_out = state.rvalid;
	assign s_axi_rdata_out = state.rdata;
	assign s_axi_rresp_out = state.rresp;
	assign pwm_out_a_out = state.pin_val[0];
	assign pwm_out_b_out = state.pin_val[1];
	assign pwm_out_c_out = state.pin_val[2];
	assign pwm_out_d_out = state.pin_val[3];
	assign pwm_oe_a_out = state.pin_oe[0];
	assign pwm_oe_b_out = state.pin_oe[1];
	assign pwm_oe_c_out = state.pin_oe[2];
	assign pwm_oe_d_out = state.pin_oe[3];
	assign shutdown_active_out = state.hold;
endmodule : pda_pwm_shutdown

//--- rtl/pda_pkg.sv
// package of constants for the pwm dead-band and auto-shutdown stage
package pda_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] DEADBAND_RESTART_CTRL_ADDR = 8'h00;
	localparam logic [7:0] SHUTDOWN_CTRL_ADDR = 8'h04;
	localparam logic [7:0] PWM_MODE_CTRL_ADDR = 8'h08;
	// values after reset
	localparam logic [7:0] DEADBAND_RESTART_CTRL_RESET = 8'h00;
	localparam logic [7:0] SHUTDOWN_CTRL_RESET = 8'h00;
	localparam logic [7:0] PWM_MODE_CTRL_RESET = 8'h00;
	// field positions
	localparam int AUTO_RESTART_BIT = 7;
	localparam int DEADBAND_COUNT_W = 7;
	localparam int FLAG_BIT = 7;
	localparam int SOURCE_LSB = 4;
	localparam int AC_LEVEL_LSB = 2;
	localparam int BD_LEVEL_LSB = 0;
	localparam int CONFIG_LSB = 6;
	localparam int ENABLE_LSB = 2;
	localparam int AC_POL_BIT = 1;
	localparam int BD_POL_BIT = 0;
	// output configurations
	localparam logic [1:0] CONFIG_SINGLE = 2'h0;
	localparam logic [1:0] CONFIG_HALF = 2'h2;
	localparam logic [1:0] CONFIG_FULL_FWD = 2'h1;
	localparam logic [1:0] CONFIG_FULL_REV = 2'h3;
	// mode bits 3:2 that select the enhanced pwm function
	localparam logic [1:0] PWM_ENABLE_CODE = 2'h3;
	// instruction cycle and clock period in ns
	localparam int TCY_NS = 400;
	localparam int MCLK_NS = 100;
	localparam int TCY_CYCLES = (TCY_NS + MCLK_NS - 1) / MCLK_NS;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pda_pkg

//--- rtl/pda_sync.sv
// two-flop synchroniser for asynchronous levels
module pda_sync #(
	parameter int WIDTH = 3
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1; // metastable stage, read by stage2 only
		logic [WIDTH-1:0] stage2; // settled copy
	} pda_sync_state_type;

	pda_sync_state_type state;
	pda_sync_state_type next_state;

	// shift one stage per clock
	always_comb begin
		next_state = state;
		next_state.stage1 = async_in;
		next_state.stage2 = state.stage1;
	end

	// synchronous reset to zero
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.stage2;
endmodule : pda_sync

//--- rtl/pda_dead_band.sv
// rising-edge delay for one half-bridge output
module pda_dead_band
	import pda_pkg::*;
#(
	parameter int CNT_W = 10,
	parameter int UNIT = TCY_CYCLES
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic level_in,
	input wire logic [DEADBAND_COUNT_W-1:0] count_in,
	output logic level_out
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt; // cycles since the active request
		logic out; // delayed level
	} pda_db_state_type;

	pda_db_state_type state;
	pda_db_state_type next_state;
	logic [CNT_W-1:0] target;

	// count up while requested; release falls at once
	always_comb begin
		next_state = state;
		target = CNT_W'(count_in) * CNT_W'(UNIT);
		if (!level_in) begin
			next_state.out = 1'b0;
			next_state.cnt = '0;
		end else if (!state.out) begin
			// a count above the active time never reaches target
			if (state.cnt >= target) begin
				next_state.out = 1'b1;
			end else begin
				next_state.cnt = state.cnt + 1'b1;
			end
		end
	end

	// registered state
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign level_out = state.out;
endmodule : pda_dead_band

//--- dv/pda_bridge_model.sv
// model of the bridge gate drivers hanging on the four pwm pins
module pda_bridge_model (
	input wire logic [3:0] pin_in,
	input wire logic [3:0] oe_in,
	output logic [3:0] gate_out
);
	// a released pin falls to the board pull-down, so its switch stays off;
	// an undriven pin never shows its last level
	assign gate_out = pin_in & oe_in;
endmodule : pda_bridge_model

//--- dv/pda_pwm_shutdown_chk.sv
// checker of bus handshakes and the shutdown hold of the pwm stage
module pda_pwm_shutdown_chk (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic period_start_in,
	input wire logic shutdown_active_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	// address and data taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// response handed over
	sequence s_b_done;
		s_axi_bvalid_out && s_axi_bready_in;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write answer off time");
	a_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	a_ready_return: assert property (s_b_done |=> s_axi_awready_out && s_axi_wready_out)
		else $error("write readies not back");
	a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read accepted while busy");
	a_rdata_byte: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
		else $error("read upper bits set");
	// hold ends only on a period boundary, so a cleared flag never cuts a period short
	a_hold_period: assert property (shutdown_active_out && !period_start_in |=> shutdown_active_out)
		else $error("hold left mid period");
	a_resume_edge: assert property ($fell(shutdown_active_out) |-> $past(period_start_in))
		else $error("resume without period start");
endmodule : pda_pwm_shutdown_chk

bind pda_pwm_shutdown pda_pwm_shutdown_chk pda_pwm_shutdown_chk_i (.mclk_in(mclk_in), .reset_in(reset_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rdata_out(s_axi_rdata_out),
	.period_start_in(period_start_in), .shutdown_active_out(shutdown_active_out));

//--- dv/test_pda_pwm_shutdown.sv
// self-checking bench of the dead-band and auto-shutdown stage
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module test_pda_pwm_shutdown import pda_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus, all set at time zero
	logic clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, c1 = 0, c2 = 0, flt_n = 1, ps = 0, raw = 0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0] dir = 4'hF;
	// observed
	logic awr, wrd, bv, arr, rv, sa;
	logic [1:0] br, rr, rresp_q, bresp_q;
	logic [31:0] rd_q;
	logic [3:0] pin, oe, gate;
	int n_fail = 0, check_count = 0;
	// 100 ns clock
	always #50 clk = ~clk;
	pda_pwm_shutdown pda_pwm_shutdown_i (.mclk_in(clk), .reset_in(rst), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
		.s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .s_axi_rdata_out(rd_q), .s_axi_rresp_out(rr),
		.comparator1_in(c1), .comparator2_in(c2), .fault_input_pin_n_in(flt_n), .period_start_in(ps),
		.pwm_raw_in(raw), .pin_dir_input_in(dir), .pwm_out_a_out(pin[0]), .pwm_out_b_out(pin[1]),
		.pwm_out_c_out(pin[2]), .pwm_out_d_out(pin[3]), .pwm_oe_a_out(oe[0]), .pwm_oe_b_out(oe[1]),
		.pwm_oe_c_out(oe[2]), .pwm_oe_d_out(oe[3]), .shutdown_active_out(sa));
	pda_bridge_model pda_bridge_model_i (.pin_in(pin), .oe_in(oe), .gate_out(gate));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one write; each channel dropped at the edge it is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'h1;
		wv <= 1'h1;
		brdy <= 1'h1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
		end while (!bv);
		bresp_q = br;
		brdy <= 1'h0;
	endtask : wr
	// one read; data taken at the edge rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rrdy <= 1'h1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		d = rd_q[7:0];
		rresp_q = rr;
		rrdy <= 1'h0;
	endtask : rd
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(nm, e, d)
	endtask : rchk
	// one-cycle period boundary
	task automatic period;
		@(posedge clk);
		ps <= 1'h1;
		@(posedge clk);
		ps <= 1'h0;
	endtask : period
	// shutdown causes: bit0 comparator 1, bit1 comparator 2, bit2 fault
	task automatic cause(input logic [2:0] v);
		@(posedge clk);
		c1 <= v[0];
		c2 <= v[1];
		flt_n <= ~v[2];
	endtask : cause
	// cycles until pin a reaches a level
	task automatic meas(input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (gate[0] !== v && n < 200);
	endtask : meas
	// pins stay inputs until a full period has run
	task automatic cfg(input logic [7:0] m, input logic [7:0] dl, input logic [7:0] s);
		wr(PWM_MODE_CTRL_ADDR, m);
		wr(DEADBAND_RESTART_CTRL_ADDR, dl);
		wr(SHUTDOWN_CTRL_ADDR, s);
		period();
		period();
		dir <= 4'h0;
		cyc(3);
	endtask : cfg
	task automatic t_reset;
		logic [7:0] d;
		@(posedge clk);
		rst <= 1'h1;
		cyc(5);
		// direction left as it was: reset alone must drop every enable
		`CHK("oe", 4'h0, oe)
		`CHK("pins", 4'h0, pin)
		rst <= 1'h0;
		dir <= 4'hF;
		cyc(2);
		wr(8'h0C, 8'h55);
		`CHK("unmapped wr resp", RESP_SLVERR, bresp_q)
		rchk("del", DEADBAND_RESTART_CTRL_ADDR, DEADBAND_RESTART_CTRL_RESET);
		rchk("asc", SHUTDOWN_CTRL_ADDR, SHUTDOWN_CTRL_RESET);
		rchk("mode", PWM_MODE_CTRL_ADDR, PWM_MODE_CTRL_RESET);
		rd(8'h0C, d);
		`CHK("unmapped resp", RESP_SLVERR, rresp_q)
		`CHK("unmapped data", 8'h00, d)
		wr(DEADBAND_RESTART_CTRL_ADDR, 8'hA5);
		`CHK("wr resp", RESP_OKAY, bresp_q)
		rchk("del rw", DEADBAND_RESTART_CTRL_ADDR, 8'hA5);
		$display("reset test done");
	endtask : t_reset
	// fault without auto restart: level a high, b low
	task automatic t_fault;
		cfg(8'h0C, 8'h00, 8'h44);
		cause(3'h4);
		cyc(4);
		`CHK("pins ab", 4'h1, gate & 4'h3)
		rchk("flag set", SHUTDOWN_CTRL_ADDR, 8'hC4);
		wr(SHUTDOWN_CTRL_ADDR, 8'h44);
		rchk("flag kept", SHUTDOWN_CTRL_ADDR, 8'hC4);
		cause(3'h0);
		cyc(4);
		rchk("no restart", SHUTDOWN_CTRL_ADDR, 8'hC4);
		wr(SHUTDOWN_CTRL_ADDR, 8'h44);
		`CHK("hold", 1'h1, sa)
		period();
		raw <= 1'h1;
		cyc(3);
		`CHK("resumed", 1'h0, sa)
		`CHK("pin a", 1'h1, gate[0])
		$display("fault test done");
	endtask : t_fault
	// full bridge both ways, and both polarities
	task automatic t_modes;
		logic [7:0] m [5] = '{8'h4C, 8'hCC, 8'h4F, 8'h0E, 8'h4D};
		logic [3:0] e [5] = '{4'h9, 4'h6, 4'h6, 4'h0, 4'h3};
		logic [3:0] k [5] = '{4'hF, 4'hF, 4'hF, 4'h1, 4'hF};
		for (int i = 0; i < 5; i++) begin
			wr(PWM_MODE_CTRL_ADDR, m[i]);
			period();
			cyc(4);
			`CHK("mode pins", e[i], gate & k[i])
		end
		raw <= 1'h0;
		$display("mode test done");
	endtask : t_modes
	// half bridge: rise delayed by count times four, fall undelayed
	task automatic t_dead;
		int rb, fb, nr, nf;
		logic [6:0] dc [2] = '{7'h0, 7'h2};
		wr(PWM_MODE_CTRL_ADDR, 8'h8C);
		for (int i = 0; i < 2; i++) begin
			wr(DEADBAND_RESTART_CTRL_ADDR, {1'h0, dc[i]});
			cyc(20);
			raw <= 1'h1;
			meas(1'h1, nr);
			`CHK("b low", 1'h0, gate[1])
			cyc(20);
			raw <= 1'h0;
			meas(1'h0, nf);
			if (i == 0) begin
				rb = nr;
				fb = nf;
			end
			`CHK("rise delay", dc[i] * TCY_CYCLES, nr - rb)
			`CHK("fall delay", 0, nf - fb)
		end
		$display("dead band test done");
	endtask : t_dead
	// every source code against every cause, auto restart on, pins released
	task automatic t_src;
		logic [7:0] s;
		wr(DEADBAND_RESTART_CTRL_ADDR, 8'h80);
		for (int c = 0; c < 8; c++) begin
			for (int i = 0; i < 3; i++) begin
				s = {1'h0, c[2:0], 4'hA};
				wr(SHUTDOWN_CTRL_ADDR, s);
				cause(3'(1 << i));
				cyc(4);
				wr(SHUTDOWN_CTRL_ADDR, s);
				rchk("source", SHUTDOWN_CTRL_ADDR, {c[i], s[6:0]});
				if (c[i]) `CHK("released", 4'h0, oe)
				cause(3'h0);
				cyc(4);
				rchk("restart", SHUTDOWN_CTRL_ADDR, s);
				period();
			end
		end
		$display("source test done");
	endtask : t_src
	// software sets the flag with no source
	task automatic t_force;
		wr(SHUTDOWN_CTRL_ADDR, 8'h80);
		cyc(2);
		`CHK("forced", 1'h1, sa)
		`CHK("forced pins", 4'h0, gate)
		wr(SHUTDOWN_CTRL_ADDR, 8'h00);
		period();
		cyc(2);
		`CHK("unforced", 1'h0, sa)
		$display("force test done");
	endtask : t_force
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	initial begin
		t_reset();
		t_fault();
		t_modes();
		t_dead();
		t_src();
		t_force();
		t_reset();
		give_verdict();
	end
	// run needs about a thousand cycles; 30000 means a hang
	initial begin
		#3000000;
		n_fail++;
		give_verdict();
	end
endmodule : test_pda_pwm_shutdown
